// >>> common/wdt_pkg.sv
// Package with constants and types shared by the watchdog timer files
package wdt_pkg;

  // Counter geometry
  localparam int          WDT_CNT_W        = 16;
  localparam logic [15:0] WDT_CNT_MAX      = 16'hffff;

  // Prescaler choices, in system clock cycles per tick
  localparam int          WDT_DIV_SLOW     = 16384;
  localparam int          WDT_DIV_FAST     = 256;
  localparam int          WDT_PRESC_W      = 14;

  // Prescaler select encoding
  localparam logic        WDT_SEL_FAST     = 1'b0;
  localparam logic        WDT_SEL_SLOW     = 1'b1;

  // Power-up defaults: 256 ticks of 256 cycles give 6.55 ms at 10 MHz
  localparam logic        WDT_SEL_RESET    = WDT_SEL_FAST;
  localparam logic [15:0] WDT_RELOAD_RESET = 16'hff00;
  localparam int          WDT_REF_FREQ_MHZ = 10;
  localparam int          WDT_DEFAULT_US   = 6500;

  // Prewarning phase before the reset request, in ticks of the prescaler
  localparam logic [15:0] WDT_PREWARN_TICKS = 16'h0001;

  // Clock of this design
  localparam int          WDT_CLK_MHZ      = 200;

  typedef enum logic [1:0] {
    WDT_ST_RUN,
    WDT_ST_OFF,
    WDT_ST_PREWARN,
    WDT_ST_RESET
  } wdt_state_t;

endpackage : wdt_pkg

// >>> rtl/wdt_prescaler.sv
// Selectable prescaler that turns the system clock into watchdog tick pulses
`timescale 1ns/10ps
module wdt_prescaler
  import wdt_pkg::*;
#(
  parameter int DIV_SLOW = WDT_DIV_SLOW,
  parameter int DIV_FAST = WDT_DIV_FAST
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic clear,
  input  wire logic run,
  input  wire logic sel,
  output logic      tick
);

  localparam logic [WDT_PRESC_W-1:0] LAST_SLOW = WDT_PRESC_W'(DIV_SLOW - 1);
  localparam logic [WDT_PRESC_W-1:0] LAST_FAST = WDT_PRESC_W'(DIV_FAST - 1);

  logic [WDT_PRESC_W-1:0] div_reg;
  logic [WDT_PRESC_W-1:0] last;

  assign last = (sel == WDT_SEL_SLOW) ? LAST_SLOW : LAST_FAST;

  always_ff @(posedge mclk) begin
    if (rst || clear) begin
      div_reg <= '0;
    end else if (run) begin
      // A lowered divisor mid-count restarts instead of running the long way round
      if (div_reg >= last) begin
        div_reg <= '0;
      end else begin
        div_reg <= div_reg + 1'b1;
      end
    end
  end

  assign tick = run && !clear && (div_reg >= last);

endmodule : wdt_prescaler

// >>> rtl/wdt_top.sv
// Watchdog timer: prescaled 16-bit counter with service, disable, enable and overflow alarm
`timescale 1ns/10ps
module wdt_top
  import wdt_pkg::*;
#(
  parameter int DIV_SLOW = WDT_DIV_SLOW,
  parameter int DIV_FAST = WDT_DIV_FAST
) (
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic                 wd_service_cmd,
  input  wire logic                 wd_disable_cmd,
  input  wire logic                 wd_enable_cmd,
  input  wire logic                 reload_wr,
  input  wire logic [WDT_CNT_W-1:0] reload_wdata,
  input  wire logic                 presc_sel_wr,
  input  wire logic                 presc_sel_wdata,
  output logic      [WDT_CNT_W-1:0] wd_count,
  output logic      [WDT_CNT_W-1:0] wd_reload_value,
  output logic                      wd_presc_sel,
  output logic                      wd_enabled,
  output logic                      wd_prewarn_irq,
  output logic                      wd_prewarn_active,
  output logic                      wd_reset_req
);

  wdt_state_t             state_reg;
  wdt_state_t             state_next;
  logic [WDT_CNT_W-1:0]   count_reg;
  logic [WDT_CNT_W-1:0]   reload_reg;
  logic                   sel_reg;
  logic [WDT_CNT_W-1:0]   warn_cnt_reg;
  logic                   irq_reg;
  logic                   rstreq_reg;
  logic                   tick;
  logic                   counting;
  logic                   service;
  logic                   overflow;
  logic                   warn_done;
  logic                   enabled_reg;
  logic                   enabled_next;
  logic                   active_reg;
  logic                   active_next;

  // Commands are ignored once the alarm sequence has started, so a runaway
  // program cannot silence a watchdog that has already fired.
  assign counting  = (state_reg == WDT_ST_RUN) || (state_reg == WDT_ST_PREWARN);
  assign service   = wd_service_cmd && (state_reg != WDT_ST_PREWARN)
                     && (state_reg != WDT_ST_RESET);
  assign overflow  = (state_reg == WDT_ST_RUN) && tick && (count_reg == WDT_CNT_MAX);
  assign warn_done = (state_reg == WDT_ST_PREWARN) && tick
                     && (warn_cnt_reg == WDT_PREWARN_TICKS - 16'h0001);

  wdt_prescaler #(
    .DIV_SLOW (DIV_SLOW),
    .DIV_FAST (DIV_FAST)
  ) u_presc (
    .mclk  (mclk),
    .rst   (rst),
    .clear (service),
    .run   (counting),
    .sel   (sel_reg),
    .tick  (tick)
  );

  always_ff @(posedge mclk) begin
    if (rst) begin
      reload_reg <= WDT_RELOAD_RESET;
    end else if (reload_wr) begin
      reload_reg <= reload_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      sel_reg <= WDT_SEL_RESET;
    end else if (presc_sel_wr) begin
      sel_reg <= presc_sel_wdata;
    end
  end

  // State sequencing
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      WDT_ST_RUN: begin
        if (overflow) begin
          state_next = WDT_ST_PREWARN;
        end else if (wd_disable_cmd) begin
          state_next = WDT_ST_OFF;
        end
      end
      WDT_ST_OFF: begin
        // enable resumes; disable wins a tie
        if (wd_enable_cmd && !wd_disable_cmd) begin
          state_next = WDT_ST_RUN;
        end
      end
      WDT_ST_PREWARN: begin
        if (warn_done) begin
          state_next = WDT_ST_RESET;
        end
      end
      WDT_ST_RESET: begin
        state_next = WDT_ST_RESET;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= WDT_ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // Flags follow the state being entered, so their registered copies change
  // on the same edge as the state register itself
  always_comb begin
    enabled_next = 1'b1;
    active_next  = 1'b0;
    unique case (state_next)
      WDT_ST_RUN: begin
        enabled_next = 1'b1;
      end
      WDT_ST_OFF: begin
        enabled_next = 1'b0;
      end
      WDT_ST_PREWARN: begin
        active_next = 1'b1;
      end
      WDT_ST_RESET: begin
        enabled_next = 1'b1;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      enabled_reg <= 1'b1;
    end else begin
      enabled_reg <= enabled_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      active_reg <= 1'b0;
    end else begin
      active_reg <= active_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      count_reg <= WDT_RELOAD_RESET;
    // service reloads counter
    // Also while disabled, so the interval can be refreshed before enabling
    end else if (service) begin
      count_reg <= reload_reg;
    end else if (tick && (state_reg == WDT_ST_RUN)) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  // Ticks spent in prewarning
  always_ff @(posedge mclk) begin
    if (rst || (state_reg != WDT_ST_PREWARN)) begin
      warn_cnt_reg <= '0;
    end else if (tick) begin
      warn_cnt_reg <= warn_cnt_reg + 16'h0001;
    end
  end

  // prewarning pulse
  // One cycle only; the interrupt controller is expected to latch it
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= overflow;
    end
  end

  // reset request held
  // Sticky until rst: whatever acts on the request may take many cycles
  always_ff @(posedge mclk) begin
    if (rst) begin
      rstreq_reg <= 1'b0;
    end else if (warn_done) begin
      rstreq_reg <= 1'b1;
    end
  end

  assign wd_count          = count_reg;
  assign wd_reload_value   = reload_reg;
  assign wd_presc_sel      = sel_reg;
  assign wd_enabled        = enabled_reg;
  assign wd_prewarn_irq    = irq_reg;
  assign wd_prewarn_active = active_reg;
  assign wd_reset_req      = rstreq_reg;

endmodule : wdt_top

// >>> bench/wdt_checker.sv
// Port assertions for the watchdog timer
`timescale 1ns/10ps
module wdt_checker
  import wdt_pkg::*;
(
  input wire logic                 mclk,
  input wire logic                 rst,
  input wire logic                 wd_service_cmd,
  input wire logic                 wd_disable_cmd,
  input wire logic                 reload_wr,
  input wire logic [WDT_CNT_W-1:0] reload_wdata,
  input wire logic                 presc_sel_wr,
  input wire logic                 presc_sel_wdata,
  input wire logic [WDT_CNT_W-1:0] wd_count,
  input wire logic [WDT_CNT_W-1:0] wd_reload_value,
  input wire logic                 wd_presc_sel,
  input wire logic                 wd_enabled,
  input wire logic                 wd_prewarn_irq,
  input wire logic                 wd_prewarn_active,
  input wire logic                 wd_reset_req
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  chk_irq_one_pulse: assert property (wd_prewarn_irq |=> !wd_prewarn_irq)
    else $error("prewarning pulse too long");
  chk_irq_on_wrap: assert property (wd_prewarn_irq |->
    wd_count == 16'h0000 && wd_prewarn_active)
    else $error("prewarning without wrap");
  chk_prewarn_cause: assert property ($rose(wd_prewarn_active) |-> wd_prewarn_irq)
    else $error("prewarning phase without pulse");
  chk_reset_sticky: assert property (wd_reset_req |=> wd_reset_req)
    else $error("reset request dropped");
  chk_reset_order: assert property ($rose(wd_reset_req) |-> $past(wd_prewarn_active))
    else $error("reset request before prewarning");
  chk_reload_write: assert property (reload_wr |=> wd_reload_value == $past(reload_wdata))
    else $error("reload value not stored");
  chk_sel_write: assert property (presc_sel_wr |=> wd_presc_sel == $past(presc_sel_wdata))
    else $error("select not stored");
  chk_disable_cmd: assert property (wd_disable_cmd && wd_enabled
    && !wd_prewarn_active && !wd_reset_req |=> !wd_enabled || wd_prewarn_irq)
    else $error("disable ignored");
  chk_service_load: assert property (wd_service_cmd && !wd_prewarn_active
    && !wd_reset_req |=> wd_count == $past(wd_reload_value))
    else $error("service did not reload");
  chk_off_frozen: assert property (!wd_enabled && !wd_service_cmd |=> $stable(wd_count))
    else $error("count moved while disabled");
endmodule : wdt_checker
bind wdt_top wdt_checker u_chk (.*);

// >>> bench/tb_wdt_top.sv
// Self-checking bench for the watchdog timer against a cycle model
`timescale 1ns/10ps
module tb_wdt_top;
  import wdt_pkg::*;
  localparam int DS = 16;
  localparam int DF = 4;
  logic mclk = 0, rst = 1, wd_service_cmd = 0, wd_disable_cmd = 0, wd_enable_cmd = 0;
  logic reload_wr = 0, presc_sel_wr = 0, presc_sel_wdata = 0, tk, m_sel, m_irq;
  logic [15:0] reload_wdata = 16'h0000, wd_count, wd_reload_value, m_cnt, m_rel;
  logic wd_presc_sel, wd_enabled, wd_prewarn_irq, wd_prewarn_active, wd_reset_req;
  logic [31:0] r = 32'hb3f8;
  int m_st, st0, m_psc, errors = 0, cmp_count = 0;
  wdt_top #(.DIV_SLOW(DS), .DIV_FAST(DF)) uut (.*);
  initial forever #2.5 mclk = ~mclk;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task close_out;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  // Model states: 0 run, 1 off, 2 prewarning, 3 reset request
  always @(posedge mclk) begin
    if (rst) begin
      m_cnt = WDT_RELOAD_RESET;
      m_rel = WDT_RELOAD_RESET;
      m_sel = WDT_SEL_RESET;
      m_st = 0;
      m_psc = 0;
      m_irq = 0;
    end else begin
      st0 = m_st;
      m_irq = 0;
      tk = (st0 == 0 || st0 == 2) && m_psc >= (m_sel ? DS : DF) - 1;
      if (st0 < 2 && wd_disable_cmd) m_st = 1;
      else if (st0 == 1 && wd_enable_cmd) m_st = 0;
      if (st0 < 2 && wd_service_cmd) begin
        m_cnt = m_rel;
        m_psc = 0;
      end else if (st0 == 0 || st0 == 2) begin
        m_psc = tk ? 0 : m_psc + 1;
        if (tk && st0 == 2) m_st = 3;
        else if (tk) begin
          m_cnt = m_cnt + 16'h0001;
          if (m_cnt == 16'h0000) begin
            m_irq = 1;
            m_st = 2;
          end
        end
      end
      if (reload_wr) m_rel = reload_wdata;
      if (presc_sel_wr) m_sel = presc_sel_wdata;
    end
  end
  always @(negedge mclk) begin
    chk("count", wd_count, m_cnt);
    chk("reload", wd_reload_value, m_rel);
    chk("select", wd_presc_sel, m_sel);
    chk("enabled", wd_enabled, m_st != 1);
    chk("irq", wd_prewarn_irq, m_irq);
    chk("prewarn", wd_prewarn_active, m_st == 2);
    chk("reset_req", wd_reset_req, m_st == 3);
  end
  initial begin
    repeat (8) @(negedge mclk);
    rst = 0;
    // Untouched default interval runs to prewarning and reset request
    repeat (1100) @(negedge mclk);
    // periodic service keeps the default interval from running out
    rst = 1;
    @(negedge mclk);
    rst = 0;
    repeat (6) begin
      repeat (1000) @(negedge mclk);
      wd_service_cmd = 1;
      @(negedge mclk);
      wd_service_cmd = 0;
    end
    chk("alarm", {wd_prewarn_active, wd_reset_req}, 2'b00);
    for (int i = 0; i < 4000; i++) begin
      @(negedge mclk);
      r = lfsr(r);
      rst = (m_st == 3) || r[31:24] == 8'h00;
      wd_service_cmd = r[3:0] == 4'h0;
      wd_disable_cmd = r[7:4] == 4'h0;
      wd_enable_cmd = r[11:8] < 4'h3;
      reload_wr = r[15:12] == 4'h0;
      reload_wdata = {12'hfff, r[19:16]};
      // Select changes only with a prescaler clear, so no divider wrap case
      presc_sel_wr = wd_service_cmd && r[20] && m_st < 2;
      presc_sel_wdata = r[21];
    end
    close_out;
  end
  initial begin
    #100us;
    errors++;
    close_out;
  end
endmodule : tb_wdt_top
